// file: design/cap_timer_pkg.sv
// Constants for the capture/event counter timer block.
// Assumes a 32-bit APB slave, byte addresses, one word per register.
package cap_timer_pkg;

    // ***************************************************
    // Register byte offsets
    // ***************************************************
    localparam logic [7:0] RUN_CTRL_OFS  = 8'h00;
    localparam logic [7:0] MODE_CTRL_OFS = 8'h04;
    localparam logic [7:0] OUT_CTRL_OFS  = 8'h08;
    localparam logic [7:0] EDGE_CTRL_OFS = 8'h0C;
    localparam logic [7:0] CNT_READ_OFS  = 8'h10;
    localparam logic [7:0] CC_BASE_OFS   = 8'h20;
    localparam int         NUM_CHAN      = 4;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int CE_POS      = 7;
    localparam int CKS_LSB     = 0;
    localparam int CKS_W       = 3;
    localparam int SOFT_TRG    = 6;
    localparam int EXT_EV_EN   = 5;
    localparam int MODE_LSB    = 0;
    localparam int MODE_W      = 3;
    localparam int TRG_SEL_LSB = 0;
    localparam int EV_SEL_LSB  = 2;
    localparam int CAP_SEL_LSB = 4;

    // ***************************************************
    // Reset and clear values
    // ***************************************************
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [15:0] CC_RST      = 16'h0000;
    localparam logic [15:0] CNT_STOPPED = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;

    // ***************************************************
    // Mode field codes and edge choices
    // ***************************************************
    localparam logic [2:0] MODE_INTERVAL = 3'h0;
    localparam logic [2:0] MODE_EXT_EVT  = 3'h1;
    localparam logic [2:0] MODE_EXT_TRG  = 3'h2;
    localparam logic [2:0] MODE_ONESHOT  = 3'h3;
    localparam logic [2:0] MODE_PWM      = 3'h4;
    localparam logic [2:0] MODE_FREERUN  = 3'h5;
    localparam logic [2:0] MODE_PWIDTH   = 3'h6;

    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage : cap_timer_pkg

// file: design/edge_detect.sv
// Synchroniser and selectable edge detector for one input pin.
// Assumes the pin holds each level for at least two clk_sys periods.
`timescale 1ns/1ns
module edge_detect (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Pin and edge choice
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    // One-cycle pulse per valid edge
    output logic            edge_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    wire  rise = sync2_reg & ~prev_reg;
    wire  fall = ~sync2_reg & prev_reg;
    logic hit;

    // Edge choice: none, rising, falling or both
    always_comb begin
        case (edge_sel)
            cap_timer_pkg::EDGE_RISE: hit = rise;
            cap_timer_pkg::EDGE_FALL: hit = fall;
            cap_timer_pkg::EDGE_BOTH: hit = rise | fall;
            default:                  hit = 1'b0;
        endcase
    end

    // Two-flop synchroniser then one pulse per edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_reg  <= 1'b0;
            sync2_reg  <= 1'b0;
            prev_reg   <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            sync1_reg  <= pin_in;
            sync2_reg  <= sync1_reg;
            prev_reg   <= sync2_reg;
            edge_pulse <= hit;
        end
    end

endmodule : edge_detect

// file: design/capture_event_counter_timer.sv
// 16-bit timer/counter with four compare channels, channel 1 also capturing, APB slave.
// Assumes asynchronous pins and a 50 MHz clk_sys.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module capture_event_counter_timer (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // External pins
    input  wire logic        event_count_input,
    input  wire logic        trigger_input,
    input  wire logic        chan1_capture_input,
    output logic [3:0]       timer_out_pin,
    // Events
    output logic             chan0_match_irq
);

    // ***************************************************
    // Registers
    // ***************************************************
    logic [7:0]  run_ctrl_reg;
    logic [7:0]  mode_ctrl_reg;
    logic [7:0]  out_ctrl_reg;
    logic [7:0]  edge_ctrl_reg;
    logic [15:0] cc_reg     [cap_timer_pkg::NUM_CHAN];
    logic [15:0] shadow_reg [cap_timer_pkg::NUM_CHAN];
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        ce_d_reg;
    logic [3:0]  toggle_reg;
    logic [7:0]  presc_reg;

    // ***************************************************
    // Field decode
    // ***************************************************
    wire       count_enable_bit = run_ctrl_reg[cap_timer_pkg::CE_POS];
    wire [2:0] clock_sel =
        run_ctrl_reg[cap_timer_pkg::CKS_LSB +: cap_timer_pkg::CKS_W];
    wire [2:0] mode_sel =
        mode_ctrl_reg[cap_timer_pkg::MODE_LSB +: cap_timer_pkg::MODE_W];
    wire       external_event_enable =
        mode_ctrl_reg[cap_timer_pkg::EXT_EV_EN];
    wire       soft_trigger_bit = mode_ctrl_reg[cap_timer_pkg::SOFT_TRG];
    wire [1:0] event_edge_sel =
        edge_ctrl_reg[cap_timer_pkg::EV_SEL_LSB +: 2];
    wire [1:0] trigger_edge_sel =
        edge_ctrl_reg[cap_timer_pkg::TRG_SEL_LSB +: 2];
    wire [1:0] capture_edge_sel =
        edge_ctrl_reg[cap_timer_pkg::CAP_SEL_LSB +: 2];

    wire ext_evt_mode = (mode_sel == cap_timer_pkg::MODE_EXT_EVT);
    wire freerun_mode = (mode_sel == cap_timer_pkg::MODE_FREERUN);
    wire pwidth_mode  = (mode_sel == cap_timer_pkg::MODE_PWIDTH);
    wire batch_mode   = (mode_sel == cap_timer_pkg::MODE_EXT_TRG) ||
                        (mode_sel == cap_timer_pkg::MODE_PWM);
    wire capture_mode = freerun_mode || pwidth_mode;

    // ***************************************************
    // Edge detectors
    // ***************************************************
    logic event_edge;
    logic trig_edge;
    logic cap_edge;

    edge_detect u_event_edge (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .pin_in     (event_count_input),
        .edge_sel   (event_edge_sel),
        .edge_pulse (event_edge)
    );

    edge_detect u_trig_edge (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .pin_in     (trigger_input),
        .edge_sel   (trigger_edge_sel),
        .edge_pulse (trig_edge)
    );

    edge_detect u_cap_edge (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .pin_in     (chan1_capture_input),
        .edge_sel   (capture_edge_sel),
        .edge_pulse (cap_edge)
    );

    // ***************************************************
    // APB decode
    // ***************************************************
    function automatic logic is_cc(input logic [7:0] a);
        return (a >= cap_timer_pkg::CC_BASE_OFS) &&
               (a < cap_timer_pkg::CC_BASE_OFS + 8'h10) &&
               (a[1:0] == 2'h0);
    endfunction : is_cc

    function automatic logic [1:0] cc_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - cap_timer_pkg::CC_BASE_OFS;
        return d[3:2];
    endfunction : cc_index

    wire setup  = psel & ~penable;
    wire wr_acc = psel & penable & pwrite & pready;
    wire hit_run  = (paddr == cap_timer_pkg::RUN_CTRL_OFS);
    wire hit_mode = (paddr == cap_timer_pkg::MODE_CTRL_OFS);
    wire hit_out  = (paddr == cap_timer_pkg::OUT_CTRL_OFS);
    wire hit_edge = (paddr == cap_timer_pkg::EDGE_CTRL_OFS);
    wire hit_cnt  = (paddr == cap_timer_pkg::CNT_READ_OFS);
    wire hit_cc   = is_cc(paddr);
    wire [1:0] cc_sel = cc_index(paddr);
    wire mapped = hit_run | hit_mode | hit_out | hit_edge |
                  hit_cnt | hit_cc;
    wire cnt_wr_bad = hit_cnt & pwrite;

    // Stopped counter reads as zero
    wire [15:0] cnt_view =
        count_enable_bit ? count_reg : cap_timer_pkg::CNT_ZERO;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_run) begin
            rd_mux[7:0] = run_ctrl_reg;
        end else if (hit_mode) begin
            rd_mux[7:0] = mode_ctrl_reg;
        end else if (hit_out) begin
            rd_mux[7:0] = out_ctrl_reg;
        end else if (hit_edge) begin
            rd_mux[7:0] = edge_ctrl_reg;
        end else if (hit_cnt) begin
            rd_mux[15:0] = cnt_view;
        end else if (hit_cc) begin
            rd_mux[15:0] = cc_reg[cc_sel];
        end
    end

    // Read data is latched whole in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & (~mapped | cnt_wr_bad);
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    wire wr_ok = wr_acc & ~pslverr;
    wire wr_run  = wr_ok & hit_run;
    wire wr_mode = wr_ok & hit_mode;
    wire wr_out  = wr_ok & hit_out;
    wire wr_edge = wr_ok & hit_edge;
    wire wr_cc   = wr_ok & hit_cc;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            run_ctrl_reg  <= cap_timer_pkg::CTRL_RST;
            mode_ctrl_reg <= cap_timer_pkg::CTRL_RST;
            out_ctrl_reg  <= cap_timer_pkg::CTRL_RST;
            edge_ctrl_reg <= cap_timer_pkg::CTRL_RST;
        end else begin
            if (wr_run) begin
                run_ctrl_reg <= pwdata[7:0];
            end
            if (wr_mode) begin
                mode_ctrl_reg <= pwdata[7:0];
            end
            if (wr_out) begin
                out_ctrl_reg <= pwdata[7:0];
            end
            if (wr_edge) begin
                edge_ctrl_reg <= pwdata[7:0];
            end
        end
    end

    // ***************************************************
    // Count clock selection
    // ***************************************************
    // Internal rate is clk_sys divided by 2**clock_sel
    logic [7:0] presc_mask;
    always_comb begin
        presc_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(clock_sel)) begin
                presc_mask[i] = 1'b1;
            end
        end
    end

    wire int_tick  = ((presc_reg & presc_mask) == presc_mask);
    wire use_event = ext_evt_mode | external_event_enable;
    wire tick = count_enable_bit &&
                (use_event ? event_edge : int_tick);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !count_enable_bit) begin
            presc_reg <= 8'h00;
        end else begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    // ***************************************************
    // Counter, match and capture
    // ***************************************************
    wire start    = count_enable_bit & ~ce_d_reg;
    // In pulse-width mode match0 is blocked; only the output compare still sees channel 0
    wire match0   = tick && !pwidth_mode &&
                    (count_reg == shadow_reg[0]);
    wire do_cap   = count_enable_bit & cap_edge & capture_mode;
    wire restart  = (mode_sel == cap_timer_pkg::MODE_EXT_TRG ||
                     mode_sel == cap_timer_pkg::MODE_ONESHOT) &&
                    (trig_edge | soft_trigger_bit);

    always_comb begin
        count_next = count_reg;
        if (!count_enable_bit) begin
            count_next = cap_timer_pkg::CNT_STOPPED;
        end else if (start) begin
            count_next = cap_timer_pkg::CNT_ZERO;
        end else if (do_cap && pwidth_mode) begin
            count_next = cap_timer_pkg::CNT_ZERO;
        end else if (restart) begin
            count_next = cap_timer_pkg::CNT_ZERO;
        end else if (match0 && !freerun_mode) begin
            count_next = cap_timer_pkg::CNT_ZERO;
        end else if (tick) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_reg       <= cap_timer_pkg::CNT_STOPPED;
            ce_d_reg        <= 1'b0;
            chan0_match_irq <= 1'b0;
        end else begin
            count_reg       <= count_next;
            ce_d_reg        <= count_enable_bit;
            chan0_match_irq <= match0 & ~start;
        end
    end

    // ***************************************************
    // Capture/compare channels and shadows
    // ***************************************************
    // Shadow reload happens at enable, and at each channel 0
    // clear in batch modes, not at trigger restarts; otherwise it follows writes
    wire reload = start | (match0 & batch_mode);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int k = 0; k < cap_timer_pkg::NUM_CHAN; k++) begin
                cc_reg[k]     <= cap_timer_pkg::CC_RST;
                shadow_reg[k] <= cap_timer_pkg::CC_RST;
            end
        end else begin
            for (int k = 0; k < cap_timer_pkg::NUM_CHAN; k++) begin
                if (k == 1 && do_cap) begin
                    cc_reg[k] <= count_reg;
                end else if (wr_cc && cc_sel == 2'(k) &&
                             !(k == 1 && pwidth_mode)) begin
                    cc_reg[k] <= pwdata[15:0];
                end
                if (reload || !batch_mode) begin
                    shadow_reg[k] <= cc_reg[k];
                end
            end
        end
    end

    // ***************************************************
    // Output controller
    // ***************************************************
    logic [3:0] out_en;
    logic [3:0] out_lvl;
    logic [3:0] ch_match;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            out_en[k]   = out_ctrl_reg[2 * k];
            out_lvl[k]  = out_ctrl_reg[2 * k + 1];
            ch_match[k] = tick && (count_reg == shadow_reg[k]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            toggle_reg    <= 4'h0;
            timer_out_pin <= 4'h0;
        end else begin
            if (!count_enable_bit) begin
                toggle_reg <= 4'h0;
            end else begin
                toggle_reg <= toggle_reg ^ ch_match;
            end
            if (ext_evt_mode) begin
                timer_out_pin <= 4'h0;
            end else begin
                timer_out_pin <= out_en &
                                 (out_lvl ^ toggle_reg);
            end
        end
    end

endmodule : capture_event_counter_timer

// file: verif/cap_timer_asserts.sv
// Concurrent checks on the capture/event counter timer ports.
// Assumes the APB master holds each request until pready is sampled.
`timescale 1ns/1ns
module cap_timer_asserts (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Pins and events
    input wire logic        event_count_input,
    input wire logic        trigger_input,
    input wire logic        chan1_capture_input,
    input wire logic [3:0]  timer_out_pin,
    input wire logic        chan0_match_irq
);
    // ***************************************************
    // Register shadows seen from the bus, and event pin age
    // ***************************************************
    logic       run_q;
    logic [2:0] mode_q;
    logic [3:0] oe_q;
    logic       ev_prev;
    logic [5:0] ev_age;
    wire        wr_done = psel && penable && pready && pwrite && !pslverr;
    wire        rd_done = psel && penable && pready && !pwrite;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            run_q   <= 1'b0;
            mode_q  <= 3'h0;
            oe_q    <= 4'h0;
            ev_prev <= 1'b0;
            ev_age  <= 6'h3F;
        end else begin
            if (wr_done && paddr == cap_timer_pkg::RUN_CTRL_OFS) begin
                run_q <= pwdata[7];
            end
            if (wr_done && paddr == cap_timer_pkg::MODE_CTRL_OFS) begin
                mode_q <= pwdata[2:0];
            end
            if (wr_done && paddr == cap_timer_pkg::OUT_CTRL_OFS) begin
                oe_q <= {pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
            end
            ev_prev <= event_count_input;
            if (ev_prev != event_count_input) begin
                ev_age <= 6'h00;
            end else if (ev_age != 6'h3F) begin
                ev_age <= ev_age + 6'h01;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable && pready;
    endsequence

    chk_ready_after_setup: assert property (
        apb_setup |=> apb_access)
        else $error("pready missing after setup");
    chk_ready_only_access: assert property (
        pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access cycle");
    chk_irq_single_pulse: assert property (
        $rose(chan0_match_irq) |=> !chan0_match_irq)
        else $error("match request longer than one cycle");
    chk_out_disabled: assert property (
        (timer_out_pin & ~(oe_q | $past(oe_q))) == 4'h0)
        else $error("output pin driven while disabled");
    chk_stopped_reads_zero: assert property (
        rd_done && paddr == cap_timer_pkg::CNT_READ_OFS &&
        !run_q && !$past(run_q) |-> prdata == 32'h0000_0000)
        else $error("stopped counter did not read zero");
    chk_stopped_no_irq: assert property (
        !run_q && !$past(run_q) && !$past(run_q, 2) |-> !chan0_match_irq)
        else $error("match request while stopped");
    chk_cnt_write_refused: assert property (
        apb_access and (pwrite && paddr == cap_timer_pkg::CNT_READ_OFS)
        |-> pslverr)
        else $error("counter read register accepted a write");
    chk_event_irq_cause: assert property (
        run_q && mode_q == cap_timer_pkg::MODE_EXT_EVT && chan0_match_irq
        |-> ev_age < 6'h0A)
        else $error("event mode match without a recent event edge");
    chk_cc_upper_zero: assert property (
        rd_done && paddr[7:4] == 4'h2 |-> prdata[31:16] == 16'h0000)
        else $error("capture register wider than 16 bits");
endmodule : cap_timer_asserts

bind capture_event_counter_timer cap_timer_asserts chk_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .event_count_input(event_count_input),
    .trigger_input(trigger_input), .chan1_capture_input(chan1_capture_input),
    .timer_out_pin(timer_out_pin), .chan0_match_irq(chan0_match_irq)
);

// file: verif/pin_source_model.sv
// External pin source: event, capture and trigger lines of the timer.
// Assumes tasks are entered right after a rising clk_sys edge.
`timescale 1ns/1ns
module pin_source_model (
    // Clock
    input  wire logic clk_sys,
    // Pins toward the timer
    output logic      event_count_input,
    output logic      chan1_capture_input,
    output logic      trigger_input
);
    initial begin
        event_count_input   = 1'b0;
        chan1_capture_input = 1'b0;
        trigger_input       = 1'b0;
    end

    // Full pulses, each level held at least two clocks
    task automatic pulses(input bit cap, input int n, input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        for (int i = 0; i < n; i++) begin
            if (cap) chan1_capture_input <= 1'b1;
            else event_count_input <= 1'b1;
            repeat (h) @(posedge clk_sys);
            if (cap) chan1_capture_input <= 1'b0;
            else event_count_input <= 1'b0;
            repeat (h) @(posedge clk_sys);
        end
    endtask : pulses
endmodule : pin_source_model

// file: verif/capture_event_counter_timer_tb.sv
// Self-checking bench for the capture/event counter timer.
// Assumes zero-wait APB slave and the pin source model on the pins.
`timescale 1ns/1ns
module capture_event_counter_timer_tb;
    logic        clk_sys, sys_rst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, chan0_match_irq;
    logic        event_count_input, trigger_input, chan1_capture_input;
    logic [3:0]  timer_out_pin;
    int          mismatches, checked, irq_cnt;

    capture_event_counter_timer dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .event_count_input(event_count_input), .trigger_input(trigger_input),
        .chan1_capture_input(chan1_capture_input),
        .timer_out_pin(timer_out_pin), .chan0_match_irq(chan0_match_irq));
    pin_source_model src_u (.clk_sys(clk_sys),
        .event_count_input(event_count_input),
        .chan1_capture_input(chan1_capture_input),
        .trigger_input(trigger_input));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (chan0_match_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // ***************************************************
    // Shared tasks
    // ***************************************************
    task finish_test;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task check(input string       nm,
               input logic [31:0] seen,
               input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 50) begin
            mismatches++;
            finish_test;
        end
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rdr(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rdr

    task wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (chan0_match_irq !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            finish_test;
        end
    endtask : wait_irq

    // ***************************************************
    // Scenarios
    // ***************************************************
    task automatic t_reset;
        logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                               8'h20, 8'h24, 8'h28, 8'h2C};
        foreach (ofs[i]) begin
            rdr(ofs[i]);
            check("reset_value", rd, 32'h0);
        end
        rdr(cap_timer_pkg::CNT_READ_OFS);
        check("cnt_stopped", rd, 32'h0);
        rdr(8'h40);
        check("unmapped_err", {31'h0, er}, 32'h1);
        wr(cap_timer_pkg::CNT_READ_OFS, 32'h5);
        check("cnt_write_err", {31'h0, er}, 32'h1);
    endtask : t_reset

    task automatic t_events;
        int exp_n[4] = '{0, 2, 2, 4};
        int n0;
        wr(cap_timer_pkg::MODE_CTRL_OFS, 32'h1);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h64);
        for (int k = 0; k < 4; k++) begin
            wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
            wr(cap_timer_pkg::EDGE_CTRL_OFS, 32'(k << 2));
            wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
            rdr(cap_timer_pkg::CNT_READ_OFS);
            check("evt_start", rd, 32'h0);
            src_u.pulses(1'b0, 2, 3);
            repeat (6) @(posedge clk_sys);
            rdr(cap_timer_pkg::CNT_READ_OFS);
            check("evt_edges", rd, 32'(exp_n[k]));
        end
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
        wr(cap_timer_pkg::EDGE_CTRL_OFS, 32'h4);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h3);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
        n0 = irq_cnt;
        src_u.pulses(1'b0, 3, 3);
        repeat (6) @(posedge clk_sys);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        check("evt_three", rd, 32'h3);
        check("evt_no_irq", 32'(irq_cnt - n0), 32'h0);
        src_u.pulses(1'b0, 1, 3);
        repeat (6) @(posedge clk_sys);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        check("evt_clear", rd, 32'h0);
        check("evt_irq", 32'(irq_cnt - n0), 32'h1);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        check("evt_stop", rd, 32'h0);
    endtask : t_events

    task t_interval;
        int p;
        wr(cap_timer_pkg::OUT_CTRL_OFS, 32'hAA);
        wr(cap_timer_pkg::MODE_CTRL_OFS, 32'h0);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h9);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
        wait_irq(p);
        wait_irq(p);
        check("int_period", 32'(p), 32'hA);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h6);
        wait_irq(p);
        wait_irq(p);
        check("int_rewrite", 32'(p), 32'h7);
        check("out_off", {28'h0, timer_out_pin}, 32'h0);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
        // PWM: a new compare value waits for the running period to end
        wr(cap_timer_pkg::MODE_CTRL_OFS, 32'h4);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h9);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
        wait_irq(p);
        wr(cap_timer_pkg::CC_BASE_OFS, 32'h1E);
        wait_irq(p);
        check("pwm_batch", 32'(p < 10), 32'h1);
        wait_irq(p);
        check("pwm_reload", 32'(p), 32'h1F);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
    endtask : t_interval

    task t_capture;
        logic [31:0] a, b, c;
        wr(cap_timer_pkg::MODE_CTRL_OFS, 32'h5);
        wr(cap_timer_pkg::EDGE_CTRL_OFS, 32'h10);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
        repeat (10) @(posedge clk_sys);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        a = rd;
        src_u.pulses(1'b1, 1, 3);
        repeat (6) @(posedge clk_sys);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        b = rd;
        rdr(cap_timer_pkg::CC_BASE_OFS + 8'h04);
        c = rd;
        check("cap_free", 32'(c > a && c < b), 32'h1);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
        wr(cap_timer_pkg::MODE_CTRL_OFS, 32'h6);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h80);
        repeat (40) @(posedge clk_sys);
        src_u.pulses(1'b1, 1, 3);
        repeat (6) @(posedge clk_sys);
        rdr(cap_timer_pkg::CNT_READ_OFS);
        a = rd;
        rdr(cap_timer_pkg::CC_BASE_OFS + 8'h04);
        c = rd;
        check("pw_clear", 32'(a < 20), 32'h1);
        check("pw_store", 32'(c > 30), 32'h1);
        wr(cap_timer_pkg::CC_BASE_OFS + 8'h04, 32'h77);
        rdr(cap_timer_pkg::CC_BASE_OFS + 8'h04);
        check("pw_no_write", rd, c);
        wr(cap_timer_pkg::RUN_CTRL_OFS, 32'h0);
    endtask : t_capture

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        checked = 0;
        irq_cnt = 0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_events;
        t_interval;
        t_capture;
        finish_test;
    end
endmodule : capture_event_counter_timer_tb
